// file: verilog/dma_channel_event_flags.sv
// Contract
// - Half-full flag bit 4 sets when dest pointer equals half of dest size.
// - Block flag bit 3 sets after larger of source/dest size bytes moved.
// - Block flag bit 3 also sets when a pattern match ends transfer.
// - Cell flag bit 2 sets each time cell size bytes are moved.
// - Matching selected abort interrupt aborts channel and sets flag bit 1.
// - Address error flag bit 0 sets on invalid source or destination address.
// - Full 32-bit read/write source start address register.
`timescale 1ns/10ps
module dma_channel_event_flags (
   input wire logic MCLK_I,
   input wire logic RESET_I,
   // AXI4-Lite slave
   input wire logic [7:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [7:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // Transfer engine side
   input wire dma_flags_pkg::engine_evt_t ENGINE_EVT_I,
   input wire logic CHAN_START_I,
   input wire logic [7:0] IRQ_NUM_I,
   input wire logic IRQ_VALID_I,
   output logic [31:0] SRC_START_ADDR_O,
   output logic [15:0] SOURCE_SIZE_O,
   output logic [15:0] DEST_SIZE_O,
   output logic [15:0] CELL_SIZE_O,
   output logic ABORT_REQ_O,
   output logic IRQ_O
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] src_start_r;
   logic [15:0] src_size_r;
   logic [15:0] dst_size_r;
   logic [15:0] cell_size_r;
   logic [7:0] abort_sel_r;
   logic [dma_flags_pkg::FLAG_W-1:0] mask_r;
   logic [dma_flags_pkg::FLAG_W-1:0] flags;
   logic [dma_flags_pkg::FLAG_W-1:0] flag_set;
   logic [dma_flags_pkg::FLAG_W-1:0] flag_clr;
   logic abort_r;

   // ------------------------------------------------------------
   // Write channel: address and data taken in either order
   // ------------------------------------------------------------
   logic aw_held_r;
   logic w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic do_write;
   logic wr_ok;
   logic [31:0] wmask;

   assign AWREADY_O = !aw_held_r && !BVALID_O;
   assign WREADY_O = !w_held_r && !BVALID_O;
   assign do_write = aw_held_r && w_held_r && !BVALID_O;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (AWVALID_I && AWREADY_O) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= AWADDR_I;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (WVALID_I && WREADY_O) begin
         w_held_r <= 1'b1;
         w_data_r <= WDATA_I;
         w_strb_r <= WSTRB_I;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{w_strb_r[b]}};
   end

   always_comb begin
      unique case (aw_addr_r)
         dma_flags_pkg::ADDR_IRQ_CTRL,
         dma_flags_pkg::ADDR_IRQ_MASK,
         dma_flags_pkg::ADDR_SRC_START,
         dma_flags_pkg::ADDR_SRC_SIZE,
         dma_flags_pkg::ADDR_DST_SIZE,
         dma_flags_pkg::ADDR_CELL_SIZE,
         dma_flags_pkg::ADDR_ABORT_SEL,
         dma_flags_pkg::ADDR_STATUS: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         BVALID_O <= 1'b0;
         BRESP_O <= dma_flags_pkg::RESP_OKAY;
      end else if (do_write) begin
         BVALID_O <= 1'b1;
         BRESP_O <= wr_ok ? dma_flags_pkg::RESP_OKAY : dma_flags_pkg::RESP_SLVERR;
      end else if (BREADY_I) begin
         BVALID_O <= 1'b0;
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [31:0] m);
      merge = (old & ~m) | (nw & m);
   endfunction

   logic wr_hit;
   assign wr_hit = do_write && wr_ok;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         src_start_r <= dma_flags_pkg::SRC_START_RST;
      end else if (wr_hit && aw_addr_r == dma_flags_pkg::ADDR_SRC_START) begin
         src_start_r <= merge(src_start_r, w_data_r, wmask);
      end
   end

   logic [31:0] sz_src_m;
   logic [31:0] sz_dst_m;
   logic [31:0] sz_cell_m;
   logic [31:0] sel_m;
   logic [31:0] msk_m;
   assign sz_src_m = merge({16'h0000, src_size_r}, w_data_r, wmask);
   assign sz_dst_m = merge({16'h0000, dst_size_r}, w_data_r, wmask);
   assign sz_cell_m = merge({16'h0000, cell_size_r}, w_data_r, wmask);
   assign sel_m = merge({24'h000000, abort_sel_r}, w_data_r, wmask);
   assign msk_m = merge({27'h0000000, mask_r}, w_data_r, wmask);

   // A zero cell or dest size disables its cell or half-full event; the block event stops only when both sizes are zero
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         src_size_r <= dma_flags_pkg::SIZE_RST;
      end else if (wr_hit && aw_addr_r == dma_flags_pkg::ADDR_SRC_SIZE) begin
         src_size_r <= sz_src_m[15:0];
      end
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         dst_size_r <= dma_flags_pkg::SIZE_RST;
      end else if (wr_hit && aw_addr_r == dma_flags_pkg::ADDR_DST_SIZE) begin
         dst_size_r <= sz_dst_m[15:0];
      end
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         cell_size_r <= dma_flags_pkg::SIZE_RST;
      end else if (wr_hit && aw_addr_r == dma_flags_pkg::ADDR_CELL_SIZE) begin
         cell_size_r <= sz_cell_m[15:0];
      end
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         abort_sel_r <= dma_flags_pkg::ABORT_SEL_RST;
      end else if (wr_hit && aw_addr_r == dma_flags_pkg::ADDR_ABORT_SEL) begin
         abort_sel_r <= sel_m[7:0];
      end
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         mask_r <= dma_flags_pkg::MASK_RST;
      end else if (wr_hit && aw_addr_r == dma_flags_pkg::ADDR_IRQ_MASK) begin
         mask_r <= msk_m[dma_flags_pkg::FLAG_W-1:0];
      end
   end

   // Write one to clear, only on lanes that are enabled
   assign flag_clr = (wr_hit && aw_addr_r == dma_flags_pkg::ADDR_IRQ_CTRL && w_strb_r[0]) ?
                     w_data_r[dma_flags_pkg::FLAG_W-1:0] : '0;

   // ------------------------------------------------------------
   // Event detection
   // ------------------------------------------------------------
   logic [15:0] block_len;
   logic half_pt_r;
   logic block_hit;
   logic cell_hit;
   logic src_bad_r;
   logic dst_bad_r;

   // Larger of the two sizes defines the block
   assign block_len = (src_size_r > dst_size_r) ? src_size_r : dst_size_r;

   // Edge of the equality so a stalled pointer does not retrigger
   logic half_eq;
   assign half_eq = ENGINE_EVT_I.dest_pointer == {1'b0, dst_size_r[15:1]} &&
                    dst_size_r != 16'h0000;
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         half_pt_r <= 1'b0;
      end else begin
         half_pt_r <= half_eq;
      end
   end

   dma_counter u_block_cnt (
      .clk_i(MCLK_I),
      .rst_i(RESET_I),
      .restart_i(CHAN_START_I),
      .step_i(ENGINE_EVT_I.byte_moved),
      .limit_i(block_len),
      .hit_o(block_hit)
   );

   dma_counter u_cell_cnt (
      .clk_i(MCLK_I),
      .rst_i(RESET_I),
      .restart_i(CHAN_START_I),
      .step_i(ENGINE_EVT_I.byte_moved),
      .limit_i(cell_size_r),
      .hit_o(cell_hit)
   );

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         src_bad_r <= 1'b0;
         dst_bad_r <= 1'b0;
      end else begin
         src_bad_r <= ENGINE_EVT_I.src_addr_bad;
         dst_bad_r <= ENGINE_EVT_I.dst_addr_bad;
      end
   end

   // Abort request to the engine is registered: high one cycle after each cycle of a matching valid interrupt
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         abort_r <= 1'b0;
      end else begin
         abort_r <= IRQ_VALID_I && IRQ_NUM_I == abort_sel_r;
      end
   end
   assign ABORT_REQ_O = abort_r;

   always_comb begin
      flag_set = '0;
      flag_set[dma_flags_pkg::BIT_HALF] = half_eq && !half_pt_r;
      flag_set[dma_flags_pkg::BIT_BLOCK] = block_hit
                                           || ENGINE_EVT_I.pattern_match;
      flag_set[dma_flags_pkg::BIT_CELL] = cell_hit;
      flag_set[dma_flags_pkg::BIT_ABORT] = abort_r;
      flag_set[dma_flags_pkg::BIT_ADDR_ERR] = src_bad_r || dst_bad_r;
   end

   for (genvar i = 0; i < dma_flags_pkg::FLAG_W; i++) begin : g_flag
      dma_flag_cell u_flag (
         .clk_i(MCLK_I),
         .rst_i(RESET_I),
         .set_i(flag_set[i]),
         .clr_i(flag_clr[i]),
         .flag_o(flags[i])
      );
   end

   // Level interrupt while any unmasked flag is pending
   // Registered so the pin never glitches; it trails the flags by one cycle
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= |(flags & mask_r);
      end
   end

   // ------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------
   logic [31:0] rd_val;
   logic rd_ok;

   assign ARREADY_O = !RVALID_O;

   always_comb begin
      rd_ok = 1'b1;
      unique case (ARADDR_I)
         dma_flags_pkg::ADDR_IRQ_CTRL: rd_val = {27'h0000000, flags};
         dma_flags_pkg::ADDR_IRQ_MASK: rd_val = {27'h0000000, mask_r};
         dma_flags_pkg::ADDR_SRC_START: rd_val = src_start_r;
         dma_flags_pkg::ADDR_SRC_SIZE: rd_val = {16'h0000, src_size_r};
         dma_flags_pkg::ADDR_DST_SIZE: rd_val = {16'h0000, dst_size_r};
         dma_flags_pkg::ADDR_CELL_SIZE: rd_val = {16'h0000, cell_size_r};
         dma_flags_pkg::ADDR_ABORT_SEL: rd_val = {24'h000000, abort_sel_r};
         dma_flags_pkg::ADDR_STATUS: rd_val = {27'h0000000, flags & mask_r};
         default: begin
            rd_val = 32'h0000_0000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         RVALID_O <= 1'b0;
         RDATA_O <= 32'h0000_0000;
         RRESP_O <= dma_flags_pkg::RESP_OKAY;
      end else if (ARVALID_I && ARREADY_O) begin
         RVALID_O <= 1'b1;
         RDATA_O <= rd_val;
         RRESP_O <= rd_ok ? dma_flags_pkg::RESP_OKAY : dma_flags_pkg::RESP_SLVERR;
      end else if (RREADY_I) begin
         RVALID_O <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Engine configuration outputs
   // ------------------------------------------------------------
   // Address is passed as written; it must already be a physical one
   assign SRC_START_ADDR_O = src_start_r;
   assign SOURCE_SIZE_O = src_size_r;
   assign DEST_SIZE_O = dst_size_r;
   assign CELL_SIZE_O = cell_size_r;
endmodule

// file: verilog/dma_flags_pkg.sv
package dma_flags_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h00;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h04;
   localparam logic [7:0] ADDR_SRC_START = 8'h08;
   localparam logic [7:0] ADDR_SRC_SIZE = 8'h0c;
   localparam logic [7:0] ADDR_DST_SIZE = 8'h10;
   localparam logic [7:0] ADDR_CELL_SIZE = 8'h14;
   localparam logic [7:0] ADDR_ABORT_SEL = 8'h18;
   localparam logic [7:0] ADDR_STATUS = 8'h1c;
   localparam int ADDR_W = 8;

   // ------------------------------------------------------------
   // Flag bit positions
   // ------------------------------------------------------------
   localparam int FLAG_W = 5;
   localparam int BIT_ADDR_ERR = 0;
   localparam int BIT_ABORT = 1;
   localparam int BIT_CELL = 2;
   localparam int BIT_BLOCK = 3;
   localparam int BIT_HALF = 4;

   localparam logic [31:0] SRC_START_RST = 32'h0000_0000;
   localparam logic [15:0] SIZE_RST = 16'h0000;
   localparam logic [7:0] ABORT_SEL_RST = 8'hff;
   localparam logic [FLAG_W-1:0] MASK_RST = 5'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ------------------------------------------------------------
   // Engine event carrier
   // ------------------------------------------------------------
   typedef struct packed {
      logic byte_moved;
      logic [15:0] dest_pointer;
      logic [15:0] src_pointer;
      logic pattern_match;
      logic src_addr_bad;
      logic dst_addr_bad;
   } engine_evt_t;
endpackage

// file: verilog/dma_flag_cell.sv
`timescale 1ns/10ps
module dma_flag_cell (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   // Set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         flag_o <= 1'b0;
      end else if (set_i) begin
         flag_o <= 1'b1;
      end else if (clr_i) begin
         flag_o <= 1'b0;
      end
   end
endmodule

// file: verilog/dma_counter.sv
`timescale 1ns/10ps
module dma_counter (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic restart_i,
   input wire logic step_i,
   input wire logic [15:0] limit_i,
   output logic hit_o
);
   // ------------------------------------------------------------
   // Byte counter wrapping at limit, pulses on each wrap
   // ------------------------------------------------------------
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;

   assign cnt_nxt = cnt_r + 16'h0001;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_r <= 16'h0000;
         hit_o <= 1'b0;
      end else if (restart_i) begin
         cnt_r <= 16'h0000;
         hit_o <= 1'b0;
      end else begin
         hit_o <= 1'b0;
         if (step_i) begin
            if (limit_i != 16'h0000 && cnt_nxt >= limit_i) begin
               cnt_r <= 16'h0000;
               hit_o <= 1'b1;
            end else begin
               cnt_r <= cnt_nxt;
            end
         end
      end
   end
endmodule

// file: test/dma_flags_sva.sv
`timescale 1ns/10ps
module dma_flags_sva (
   input wire logic MCLK_I,
   input wire logic RESET_I,
   input wire logic ARVALID_I,
   input wire logic BREADY_I,
   input wire logic RREADY_I,
   input wire logic IRQ_VALID_I,
   input wire logic AWREADY_O,
   input wire logic WREADY_O,
   input wire logic [1:0] BRESP_O,
   input wire logic BVALID_O,
   input wire logic ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic RVALID_O,
   input wire logic ABORT_REQ_O,
   input wire logic IRQ_O
);
   // ----------
   // Bus and abort checks
   // ----------
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RESET_I);
   wr_hold_a:
      assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
      else $error("write response changed before accept");
   rd_hold_a:
      assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data changed before accept");
   wr_busy_a:
      assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
      else $error("write taken while response pending");
   rd_busy_a:
      assert property (RVALID_O |-> !ARREADY_O) else $error("read taken while busy");
   wr_done_a:
      assert property (BVALID_O && BREADY_I |=> !BVALID_O) else $error("write response repeated");
   rd_done_a:
      assert property (RVALID_O && RREADY_I |=> !RVALID_O) else $error("read response repeated");
   rd_cause_a:
      assert property ($rose(RVALID_O) |-> $past(ARVALID_I) && $past(ARREADY_O))
      else $error("read answer without request");
   abort_cause_a:
      assert property (ABORT_REQ_O |-> $past(IRQ_VALID_I)) else $error("abort without interrupt");
   cover property (ABORT_REQ_O);
   cover property ($rose(IRQ_O));
   cover property (BVALID_O && BRESP_O == 2'b10);
endmodule
bind dma_channel_event_flags dma_flags_sva u_sva (.MCLK_I, .RESET_I, .ARVALID_I, .BREADY_I,
   .RREADY_I, .IRQ_VALID_I, .AWREADY_O, .WREADY_O, .BRESP_O, .BVALID_O, .ARREADY_O,
   .RDATA_O, .RVALID_O, .ABORT_REQ_O, .IRQ_O);

// file: test/dma_engine_model.sv
`timescale 1ns/10ps
module dma_engine_model (
   input wire logic clk_i,
   output dma_flags_pkg::engine_evt_t evt_o
);
   // ----------
   // Byte mover, prompt or with idle gaps
   // ----------
   initial evt_o = '0;
   task automatic restart();
      @(posedge clk_i);
      evt_o.dest_pointer <= 16'h0000;
   endtask
   task automatic move(input int n, input int gap);
      repeat (n) begin
         @(posedge clk_i);
         evt_o.byte_moved <= 1'b1;
         evt_o.dest_pointer <= evt_o.dest_pointer + 16'h0001;
         if (gap > 0) begin
            @(posedge clk_i);
            evt_o.byte_moved <= 1'b0;
            repeat (gap - 1) @(posedge clk_i);
         end
      end
      @(posedge clk_i);
      evt_o.byte_moved <= 1'b0;
   endtask
   // Pattern, source error, destination error: one-cycle pulses
   task automatic flag(input logic [2:0] m);
      @(posedge clk_i);
      evt_o[2:0] <= m;
      @(posedge clk_i);
      evt_o[2:0] <= 3'h0;
   endtask
endmodule

// file: test/dma_channel_event_flags_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end
module dma_channel_event_flags_tb_top;
   // ----------
   // Harness
   // ----------
   localparam logic [7:0] A_FLG = dma_flags_pkg::ADDR_IRQ_CTRL;
   localparam logic [7:0] A_MSK = dma_flags_pkg::ADDR_IRQ_MASK;
   localparam logic [7:0] A_SRC = dma_flags_pkg::ADDR_SRC_START;
   localparam logic [1:0] OK = dma_flags_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = dma_flags_pkg::RESP_SLVERR;
   logic MCLK_I, RESET_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
   logic CHAN_START_I, IRQ_VALID_I, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
   logic ABORT_REQ_O, IRQ_O;
   logic [7:0] AWADDR_I, ARADDR_I, IRQ_NUM_I;
   logic [31:0] WDATA_I, RDATA_O, SRC_START_ADDR_O;
   logic [3:0] WSTRB_I;
   logic [1:0] BRESP_O, RRESP_O;
   logic [15:0] SOURCE_SIZE_O, DEST_SIZE_O, CELL_SIZE_O;
   dma_flags_pkg::engine_evt_t ENGINE_EVT_I;
   int n_errors = 0;
   int num_checks = 0;
   dma_channel_event_flags DUT (.MCLK_I, .RESET_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I,
      .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I,
      .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .ENGINE_EVT_I, .CHAN_START_I,
      .IRQ_NUM_I, .IRQ_VALID_I, .SRC_START_ADDR_O, .SOURCE_SIZE_O, .DEST_SIZE_O,
      .CELL_SIZE_O, .ABORT_REQ_O, .IRQ_O);
   dma_engine_model eng (.clk_i(MCLK_I), .evt_o(ENGINE_EVT_I));
   initial begin
      MCLK_I = 1'b0;
      forever #2 MCLK_I = ~MCLK_I;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic hang();
      n_errors++;
      $display("BAD %0t wait ran out", $time);
      end_of_test();
   endtask
   // Both halves offered together, each dropped as it is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge MCLK_I);
      AWADDR_I <= a;
      WDATA_I <= d;
      {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
      for (i = 0; i < 50; i++) begin
         @(posedge MCLK_I);
         if (AWREADY_O) AWVALID_I <= 1'b0;
         if (WREADY_O) WVALID_I <= 1'b0;
         if (BVALID_O) break;
      end
      if (i == 50) hang();
      `CHK(BRESP_O, er)
      BREADY_I <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      @(posedge MCLK_I);
      ARADDR_I <= a;
      {ARVALID_I, RREADY_I} <= 2'h3;
      for (i = 0; i < 50; i++) begin
         @(posedge MCLK_I);
         if (ARREADY_O) ARVALID_I <= 1'b0;
         if (RVALID_O) break;
      end
      if (i == 50) hang();
      `CHK(RDATA_O, ed)
      `CHK(RRESP_O, er)
      RREADY_I <= 1'b0;
   endtask
   task automatic start();
      eng.restart();
      @(posedge MCLK_I);
      CHAN_START_I <= 1'b1;
      @(posedge MCLK_I);
      CHAN_START_I <= 1'b0;
   endtask
   task automatic irq(input logic [7:0] n, input logic e);
      @(posedge MCLK_I);
      IRQ_NUM_I <= n;
      IRQ_VALID_I <= 1'b1;
      @(posedge MCLK_I);
      IRQ_VALID_I <= 1'b0;
      @(posedge MCLK_I);
      `CHK(ABORT_REQ_O, e)
   endtask
   // ----------
   // Scenarios
   // ----------
   task automatic t_regs();
      rd(A_SRC, 32'h0, OK);
      rd(A_FLG, 32'h0, OK);
      rd(8'h20, 32'h0, ERR);
      wr(A_SRC, 32'ha5c3_5a3c, OK);
      wr(8'h24, 32'hffff_ffff, ERR);
      rd(A_SRC, 32'ha5c3_5a3c, OK);
      `CHK(SRC_START_ADDR_O, 32'ha5c3_5a3c)
      WSTRB_I <= 4'h1;
      wr(A_SRC, 32'h0000_00ff, OK);
      WSTRB_I <= 4'hf;
      rd(A_SRC, 32'ha5c3_5aff, OK);
      rd(dma_flags_pkg::ADDR_ABORT_SEL, 32'hff, OK);
      $display("registers done");
   endtask
   task automatic t_count();
      wr(dma_flags_pkg::ADDR_SRC_SIZE, 32'h8, OK);
      wr(dma_flags_pkg::ADDR_DST_SIZE, 32'h6, OK);
      wr(dma_flags_pkg::ADDR_CELL_SIZE, 32'h4, OK);
      wr(A_MSK, 32'h1f, OK);
      `CHK(SOURCE_SIZE_O, 16'h0008)
      `CHK(DEST_SIZE_O, 16'h0006)
      `CHK(CELL_SIZE_O, 16'h0004)
      start();
      eng.move(7, 0);
      rd(A_FLG, 32'h14, OK);
      `CHK(IRQ_O, 1'b1)
      wr(A_FLG, 32'h14, OK);
      eng.move(1, 2);
      rd(A_FLG, 32'h0c, OK);
      wr(A_FLG, 32'h1f, OK);
      rd(A_FLG, 32'h0, OK);
      `CHK(IRQ_O, 1'b0)
      start();
      eng.move(2, 0);
      eng.flag(3'h4);
      rd(A_FLG, 32'h08, OK);
      wr(A_FLG, 32'h08, OK);
      $display("counts done");
   endtask
   task automatic t_events();
      wr(dma_flags_pkg::ADDR_ABORT_SEL, 32'h2a, OK);
      irq(8'h29, 1'b0);
      irq(8'h2a, 1'b1);
      rd(A_FLG, 32'h02, OK);
      wr(A_FLG, 32'h02, OK);
      wr(A_MSK, 32'h0, OK);
      eng.flag(3'h2);
      rd(A_FLG, 32'h01, OK);
      `CHK(IRQ_O, 1'b0)
      wr(A_MSK, 32'h01, OK);
      @(posedge MCLK_I);
      `CHK(IRQ_O, 1'b1)
      wr(A_FLG, 32'h01, OK);
      eng.flag(3'h1);
      rd(A_FLG, 32'h01, OK);
      rd(dma_flags_pkg::ADDR_STATUS, 32'h01, OK);
      $display("events done");
   endtask
   initial begin
      RESET_I = 1'b1;
      {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, CHAN_START_I, IRQ_VALID_I} = '0;
      {AWADDR_I, ARADDR_I, IRQ_NUM_I, WDATA_I} = '0;
      WSTRB_I = 4'hf;
      repeat (8) @(posedge MCLK_I);
      RESET_I <= 1'b0;
      t_regs();
      t_count();
      t_events();
      end_of_test();
   end
endmodule
